// [hw/mbp_host.sv]
// What this block does
// - Non-mux 8-bit: data on first port
// - Non-mux 16-bit: high byte second port
// - Wide host: A16-18 third port, A19 top
// - Odd mux host wired non-mux, strobe kept
`include "mbp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mbp_host #(
    parameter int ALE_CYC  = `MBP_ALE_CYC,   // Strobe width in cycles
    parameter int HOLD_CYC = `MBP_HOLD_CYC,  // Address hold in cycles
    parameter int STB_CYC  = `MBP_STB_CYC,   // Read/write strobe in cycles
    parameter int REC_CYC  = `MBP_REC_CYC    // Recovery in cycles
) (
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    // User side
    input  wire logic                i_req,
    input  wire logic                i_write,
    input  wire logic [19:0]         i_addr,
    input  wire logic [15:0]         i_wdata,
    input  wire logic                i_byte_hi,
    input  wire mbp_pkg::mbp_mode_type i_mode,
    input  wire logic                i_ale_pol,
    input  wire logic                i_rw_style,
    output var  logic                o_busy,
    output var  logic                o_done,
    output var  logic [15:0]         o_rdata,
    // Device pins
    output var  logic                o_address_latch_strobe,
    output var  logic                o_read_strobe_n,
    output var  logic                o_write_ctl,
    output var  logic                o_byte_high_enable_n,
    output var  logic                o_top_address_or_select,
    output var  logic [2:0]          o_third_port_pins,
    input  wire logic [7:0]          i_low_addr_data_lines,
    output var  logic [7:0]          o_low_addr_data_lines,
    output var  logic                o_low_addr_data_oe_n,
    input  wire logic [7:0]          i_high_addr_data_lines,
    output var  logic [7:0]          o_high_addr_data_lines,
    output var  logic                o_high_addr_data_oe_n,
    input  wire logic [7:0]          i_first_port_pins,
    output var  logic [7:0]          o_first_port_pins,
    output var  logic                o_first_port_oe_n,
    input  wire logic [7:0]          i_second_port_pins,
    output var  logic [7:0]          o_second_port_pins,
    output var  logic                o_second_port_oe_n
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The phase counter is four bits wide
    if (ALE_CYC < 1 || ALE_CYC > 15 || HOLD_CYC < 1 || HOLD_CYC > 15 ||
        STB_CYC < 3 || STB_CYC > 15 || REC_CYC < 1 || REC_CYC > 15) begin : g_bad
        $error("mbp_host: phase counts must fit 1..15, strobe at least 3");
    end

    // ------------------------------------------------------------
    // Request and phase state
    // ------------------------------------------------------------
    mbp_pkg::mbp_state_type state_reg, state_next;  // Bus cycle phase
    mbp_pkg::mbp_mode_type  mode_reg, mode_next;    // Mode held per cycle
    logic [3:0]  cnt_reg, cnt_next;                 // Phase counter
    logic [19:0] addr_reg, addr_next;               // Held address
    logic [15:0] wdata_reg, wdata_next;             // Held write data
    logic        write_reg, write_next;             // Direction held
    logic        hi_reg, hi_next;                   // High byte wanted
    logic        pol_reg, pol_next;                 // Latch strobe polarity
    logic        rws_reg, rws_next;                 // Read/write select style
    logic [7:0]  lo_sync, hi_sync, pa_sync, pb_sync;  // Synchronised pins

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    mbp_sync #(.WIDTH(8)) u_sync_lo (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_low_addr_data_lines),
        .o_sync    (lo_sync)
    );
    mbp_sync #(.WIDTH(8)) u_sync_hi (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_high_addr_data_lines),
        .o_sync    (hi_sync)
    );
    mbp_sync #(.WIDTH(8)) u_sync_pa (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_first_port_pins),
        .o_sync    (pa_sync)
    );
    mbp_sync #(.WIDTH(8)) u_sync_pb (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_second_port_pins),
        .o_sync    (pb_sync)
    );

    // ------------------------------------------------------------
    // Decode of the current and next phase
    // ------------------------------------------------------------
    wire logic cnt_zero = (cnt_reg == 4'h0);
    wire logic take     = (state_reg == mbp_pkg::MBP_ST_IDLE) && i_req;
    wire logic sample   = (state_reg == mbp_pkg::MBP_ST_STROBE) && cnt_zero && !write_reg;
    wire logic finish   = (state_reg == mbp_pkg::MBP_ST_RECOVER) && cnt_zero;
    wire logic n_busy   = (state_next != mbp_pkg::MBP_ST_IDLE);
    wire logic n_ale    = (state_next == mbp_pkg::MBP_ST_ADDR);
    wire logic n_strobe = (state_next == mbp_pkg::MBP_ST_STROBE);
    wire logic n_data   = n_strobe || (state_next == mbp_pkg::MBP_ST_RECOVER);
    wire logic n_mux    = (mode_next == mbp_pkg::MBP_MUX8) ||
                          (mode_next == mbp_pkg::MBP_MUX16);
    wire logic n_mux16  = (mode_next == mbp_pkg::MBP_MUX16);
    wire logic n_nmux16 = (mode_next == mbp_pkg::MBP_NMUX16);
    wire logic n_wide   = n_mux16 || n_nmux16;
    // Mux data phase puts write data on the shared lines
    wire logic lo_data  = n_mux && n_data;
    wire logic hi_data  = n_mux16 && n_data;
    // The host lets go of lines the device answers on
    wire logic lo_rel   = !n_busy || (lo_data && !write_next);
    wire logic hi_rel   = !n_busy || (hi_data && !write_next);
    wire logic pa_drv   = !n_mux && n_data && write_next;
    wire logic pb_drv   = n_nmux16 && n_data && write_next && hi_next;
    // Trailing edge of the strobe is the leave of the address phase
    wire logic ale_pin  = pol_next ? n_ale : !n_ale;
    wire logic wr_pin   = rws_next ? !(n_busy && write_next) :
                                     !(n_strobe && write_next);
    wire logic rd_pin   = rws_next ? !n_strobe : !(n_strobe && !write_next);
    wire logic [15:0] rd_word = {
        n_mux16 ? hi_sync : (n_nmux16 ? pb_sync : 8'h00),
        n_mux ? lo_sync : pa_sync};

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    // Each phase loads its length, counts to zero, then moves on
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_zero ? 4'h0 : cnt_reg - 4'h1;
        case (state_reg)
            mbp_pkg::MBP_ST_IDLE: begin
                if (i_req) begin
                    state_next = mbp_pkg::MBP_ST_ADDR;
                    cnt_next   = 4'(ALE_CYC - 1);
                end
            end
            mbp_pkg::MBP_ST_ADDR: begin
                // Strobe stays asserted in every mode, even non-mux
                if (cnt_zero) begin
                    state_next = mbp_pkg::MBP_ST_LATCH;
                    cnt_next   = 4'(HOLD_CYC - 1);
                end
            end
            mbp_pkg::MBP_ST_LATCH: begin
                // Address held past the trailing edge
                if (cnt_zero) begin
                    state_next = mbp_pkg::MBP_ST_STROBE;
                    cnt_next   = 4'(STB_CYC - 1);
                end
            end
            mbp_pkg::MBP_ST_STROBE: begin
                if (cnt_zero) begin
                    state_next = mbp_pkg::MBP_ST_RECOVER;
                    cnt_next   = 4'(REC_CYC - 1);
                end
            end
            mbp_pkg::MBP_ST_RECOVER: begin
                if (cnt_zero) begin
                    state_next = mbp_pkg::MBP_ST_IDLE;
                end
            end
            default: begin
                state_next = mbp_pkg::MBP_ST_IDLE;
                cnt_next   = 4'h0;
            end
        endcase
    end

    // Request fields are captured once so a cycle never changes mid-way
    assign mode_next  = take ? i_mode    : mode_reg;
    assign addr_next  = take ? i_addr    : addr_reg;
    assign wdata_next = take ? i_wdata   : wdata_reg;
    assign write_next = take ? i_write   : write_reg;
    assign hi_next    = take ? i_byte_hi : hi_reg;
    assign pol_next   = take ? i_ale_pol : pol_reg;
    assign rws_next   = take ? i_rw_style : rws_reg;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg <= mbp_pkg::MBP_ST_IDLE;
            mode_reg  <= mbp_pkg::MBP_MUX8;
            cnt_reg   <= 4'h0;
            addr_reg  <= 20'h00000;
            wdata_reg <= 16'h0000;
            write_reg <= 1'b0;
            hi_reg    <= 1'b0;
            pol_reg   <= 1'b1;
            rws_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            cnt_reg   <= cnt_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            write_reg <= write_next;
            hi_reg    <= hi_next;
            pol_reg   <= pol_next;
            rws_reg   <= rws_next;
        end
    end

    // ------------------------------------------------------------
    // Registered pin and user outputs
    // ------------------------------------------------------------
    // Every output is a flop; strobes idle inactive, lines idle released
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_busy                  <= 1'b0;
            o_done                  <= 1'b0;
            o_rdata                 <= 16'h0000;
            o_address_latch_strobe  <= 1'b0;
            o_read_strobe_n         <= 1'b1;
            o_write_ctl             <= 1'b1;
            o_byte_high_enable_n    <= 1'b1;
            o_top_address_or_select <= 1'b0;
            o_third_port_pins       <= 3'h0;
            o_low_addr_data_lines   <= 8'h00;
            o_low_addr_data_oe_n    <= 1'b1;
            o_high_addr_data_lines  <= 8'h00;
            o_high_addr_data_oe_n   <= 1'b1;
            o_first_port_pins       <= 8'h00;
            o_first_port_oe_n       <= 1'b1;
            o_second_port_pins      <= 8'h00;
            o_second_port_oe_n      <= 1'b1;
        end else begin
            o_busy                  <= n_busy;
            o_done                  <= finish;
            o_rdata                 <= sample ? rd_word : o_rdata;
            o_address_latch_strobe  <= ale_pin;
            o_read_strobe_n         <= rd_pin;
            o_write_ctl             <= wr_pin;
            o_byte_high_enable_n    <= !(n_busy && n_wide && hi_next);
            o_top_address_or_select <= addr_next[`MBP_ADDR_TOP_BIT];
            // Third port always carries address bits into the decoder
            o_third_port_pins <= addr_next[`MBP_ADDR_EXT_MSB:`MBP_ADDR_EXT_LSB];
            o_low_addr_data_lines   <= lo_data ? wdata_next[7:0] :
                                       addr_next[`MBP_ADDR_LO_MSB:0];
            o_low_addr_data_oe_n    <= lo_rel;
            o_high_addr_data_lines  <= hi_data ? wdata_next[15:8] :
                                addr_next[`MBP_ADDR_HI_MSB:`MBP_ADDR_HI_LSB];
            o_high_addr_data_oe_n   <= hi_rel;
            o_first_port_pins       <= wdata_next[7:0];
            o_first_port_oe_n       <= !pa_drv;
            // Second port stays released otherwise: device owns it as I/O or selects
            o_second_port_pins      <= wdata_next[15:8];
            o_second_port_oe_n      <= !pb_drv;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire logic a_mux   = (mode_reg == mbp_pkg::MBP_MUX8) || (mode_reg == mbp_pkg::MBP_MUX16);
    wire logic a_stb   = (state_reg == mbp_pkg::MBP_ST_STROBE);
    wire logic a_ale   = (o_address_latch_strobe == pol_reg);

    sequence s_start;
        (state_reg == mbp_pkg::MBP_ST_IDLE) && i_req;
    endsequence
    sequence s_finish;
        ##[1:70] o_done;
    endsequence

    property p_cycle_ends;
        @(posedge i_mclk) disable iff (!i_reset_n) s_start |-> s_finish;
    endproperty
    a_cycle_ends: assert property (p_cycle_ends) else $error("cycle never done");

    property p_latch_before_data;
        @(posedge i_mclk) disable iff (!i_reset_n) a_stb |-> !a_ale;
    endproperty
    a_latch_before_data: assert property (p_latch_before_data)
        else $error("latch strobe active in data phase");

    property p_mux_write_data;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (a_stb && a_mux && write_reg) |-> ##1
            (!o_low_addr_data_oe_n && o_low_addr_data_lines == wdata_reg[7:0]);
    endproperty
    a_mux_write_data: assert property (p_mux_write_data)
        else $error("mux write data missing");

    property p_read_release;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (!o_read_strobe_n && !write_reg && o_busy) |->
            (o_first_port_oe_n && o_second_port_oe_n && (o_low_addr_data_oe_n || !a_mux));
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("host drives data during read");

    property p_nmux_addr_lo;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (o_busy && !a_mux) |->
            (!o_low_addr_data_oe_n && o_low_addr_data_lines == addr_reg[7:0]);
    endproperty
    a_nmux_addr_lo: assert property (p_nmux_addr_lo)
        else $error("non-mux low lines not address");

    property p_mux16_hi;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (a_stb && mode_reg == mbp_pkg::MBP_MUX16 && write_reg) |-> ##1
            (o_high_addr_data_lines == wdata_reg[15:8]);
    endproperty
    a_mux16_hi: assert property (p_mux16_hi)
        else $error("mux16 high data missing");

    property p_hi_addr_only;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (o_busy && mode_reg != mbp_pkg::MBP_MUX16) |->
            (!o_high_addr_data_oe_n && o_high_addr_data_lines == addr_reg[15:8]);
    endproperty
    a_hi_addr_only: assert property (p_hi_addr_only)
        else $error("high lines not address");

    property p_nmux16_pb;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (a_stb && mode_reg == mbp_pkg::MBP_NMUX16 && write_reg && hi_reg) |-> ##1
            (!o_second_port_oe_n && o_second_port_pins == wdata_reg[15:8]);
    endproperty
    a_nmux16_pb: assert property (p_nmux16_pb)
        else $error("second port high byte missing");

    property p_ext_addr;
        @(posedge i_mclk) disable iff (!i_reset_n)
            o_busy |-> (o_third_port_pins == addr_reg[18:16] &&
                        o_top_address_or_select == addr_reg[19]);
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");

    property p_ale_trailing;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (o_busy && $past(a_ale) && !a_ale) |->
            $stable(o_low_addr_data_lines) && !o_low_addr_data_oe_n;
    endproperty
    a_ale_trailing: assert property (p_ale_trailing)
        else $error("address moved at latch edge");

    property p_write_pulse;
        @(posedge i_mclk) disable iff (!i_reset_n)
            (!rws_reg && !o_write_ctl) |-> (write_reg && a_stb);
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write pulse outside strobe");

endmodule

`default_nettype wire

// [hw/mbp_regs.svh]
`ifndef MBP_REGS_SVH
`define MBP_REGS_SVH

// ----------------------------------------------------------------
// Clock and bus timing
// ----------------------------------------------------------------
// Local clock period in ns (40 MHz)
`define MBP_CLK_NS        25
// Least width of the address latch strobe, ns
`define MBP_T_ALE_NS      50
// Least address hold after the strobe's trailing edge, ns
`define MBP_T_HOLD_NS     25
// Least device access time under a read or write strobe, ns
`define MBP_T_ACC_NS      150
// Least recovery with data held after the strobe ends, ns
`define MBP_T_REC_NS      25
// Stages of the pin synchroniser, added to the strobe length
`define MBP_SYNC_STAGES   2

// Cycle counts, least times rounded up to whole cycles
`define MBP_ALE_CYC  ((`MBP_T_ALE_NS + `MBP_CLK_NS - 1) / `MBP_CLK_NS)
`define MBP_HOLD_CYC ((`MBP_T_HOLD_NS + `MBP_CLK_NS - 1) / `MBP_CLK_NS)
`define MBP_ACC_CYC  ((`MBP_T_ACC_NS + `MBP_CLK_NS - 1) / `MBP_CLK_NS)
`define MBP_REC_CYC  ((`MBP_T_REC_NS + `MBP_CLK_NS - 1) / `MBP_CLK_NS)
`define MBP_STB_CYC  (`MBP_ACC_CYC + `MBP_SYNC_STAGES)

// ----------------------------------------------------------------
// Field positions of the 20-bit host address
// ----------------------------------------------------------------
`define MBP_ADDR_LO_MSB   7
`define MBP_ADDR_HI_LSB   8
`define MBP_ADDR_HI_MSB   15
`define MBP_ADDR_EXT_LSB  16
`define MBP_ADDR_EXT_MSB  18
`define MBP_ADDR_TOP_BIT  19

`endif

// [hw/mbp_pkg.sv]
// ----------------------------------------------------------------
// Types shared by the bus port controller
// ----------------------------------------------------------------
package mbp_pkg;

    // Bus configuration of the attached device
    typedef enum logic [1:0] {
        MBP_MUX8,
        MBP_MUX16,
        MBP_NMUX8,
        MBP_NMUX16
    } mbp_mode_type;

    // Phases of one bus cycle
    typedef enum logic [2:0] {
        MBP_ST_IDLE,
        MBP_ST_ADDR,
        MBP_ST_LATCH,
        MBP_ST_STROBE,
        MBP_ST_RECOVER
    } mbp_state_type;

endpackage

// [hw/mbp_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module mbp_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second

    // Refuse a width that makes no bus
    if (WIDTH < 1) begin : g_bad_width
        $error("mbp_sync: WIDTH must be at least 1");
    end

    // Both stages clear on reset so reads never see stale pins
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [test/mbp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Device model on the far side of the host port
// ----------------------------------------------------------------
module mbp_dev_model (
    input  wire logic                  i_ale,
    input  wire logic                  i_pol,
    input  wire logic                  i_rws,
    input  wire mbp_pkg::mbp_mode_type i_mode,
    input  wire logic                  i_rd_n,
    input  wire logic                  i_wr,
    input  wire logic                  i_bhe_n,
    input  wire logic [31:0]           i_host,  // Host values: low, high, first, second
    input  wire logic [3:0]            i_oe_n,  // Host enables, low drives
    output var  logic [31:0]           o_bus    // Resolved pin levels
);
    logic [15:0] mem [16];  // Small word store
    logic [15:0] adr_reg;   // Address held by the latch
    logic [3:0]  drv;       // Device drives bus k
    wire  mux = !i_mode[1];  // Encodings 0 and 1 are multiplexed
    wire  w16 = i_mode[0];   // Encodings 1 and 3 are 16-bit
    wire  rd  = !i_rd_n && (!i_rws || i_wr);
    wire  wstb = i_rws ? (i_rd_n | i_wr) : i_wr;  // Rising end of a write
    wire  [15:0] rword = mem[adr_reg[3:0]];
    wire  [15:0] wword = mux ? o_bus[15:0] : o_bus[31:16];

    // Trailing edge of the strobe latches the low and high address lines
    always @(i_ale) if (i_ale == !i_pol) adr_reg = o_bus[15:0];

    // Drive only during reads, on the lines the mode names
    assign drv = {rd && w16 && !mux && !i_bhe_n, rd && !mux,
                  rd && mux && w16 && !i_bhe_n, rd && mux};

    // Released lines show the inverse, so a stale sample cannot match
    always_comb for (int k = 0; k < 4; k++)
        o_bus[8*k+:8] = !i_oe_n[k] ? i_host[8*k+:8] :
                        drv[k] ? rword[8*(k%2)+:8] : ~rword[8*(k%2)+:8];

    // Store the write; high byte only when enabled in 16-bit modes
    always @(posedge wstb) begin
        mem[adr_reg[3:0]][7:0] = wword[7:0];
        if (w16 && !i_bhe_n) mem[adr_reg[3:0]][15:8] = wword[15:8];
    end
endmodule

`default_nettype wire

// [test/tb_mcu_bus_port_modes.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_mcu_bus_port_modes;
    // ----------------------------------------------------------------
    // Rows: mode, polarity, style, write, address, data or expected read
    // ----------------------------------------------------------------
    typedef struct packed {
        mbp_pkg::mbp_mode_type m;
        logic p, s, w;
        logic [19:0] a;
        logic [15:0] d;
    } mbp_row_type;
    localparam mbp_row_type ROWS [8] = '{
        '{mbp_pkg::MBP_MUX8, 1'b1, 1'b0, 1'b1, 20'h12341, 16'hBEEF},
        '{mbp_pkg::MBP_MUX8, 1'b1, 1'b0, 1'b0, 20'h12341, 16'h00EF},
        '{mbp_pkg::MBP_MUX16, 1'b0, 1'b1, 1'b1, 20'hA5672, 16'hC3A5},
        '{mbp_pkg::MBP_MUX16, 1'b0, 1'b1, 1'b0, 20'hA5672, 16'hC3A5},
        '{mbp_pkg::MBP_NMUX8, 1'b0, 1'b0, 1'b1, 20'h5ABC3, 16'h1234},
        '{mbp_pkg::MBP_NMUX8, 1'b0, 1'b0, 1'b0, 20'h5ABC3, 16'h0034},
        '{mbp_pkg::MBP_NMUX16, 1'b1, 1'b1, 1'b1, 20'hF0F04, 16'h5AA5},
        '{mbp_pkg::MBP_NMUX16, 1'b1, 1'b1, 1'b0, 20'hF0F04, 16'h5AA5}};
    logic clk = 0, rst_n = 0, req = 0, wr = 0, bh = 1, pol = 1, rws = 0;
    logic [19:0] adr = 0;
    logic [15:0] wd = 0;
    mbp_pkg::mbp_mode_type mode = mbp_pkg::MBP_MUX8;
    wire busy, done, ale, rd_n, wctl, bhe_n, top;
    wire [15:0] rdata;
    wire [2:0]  tp;
    wire [31:0] host, bus;
    wire [3:0]  oe_n;
    int fails = 0, checks_done = 0;

    always #12.5 clk = ~clk;

    mbp_host i_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_req(req), .i_write(wr),
        .i_addr(adr), .i_wdata(wd), .i_byte_hi(bh), .i_mode(mode), .i_ale_pol(pol),
        .i_rw_style(rws), .o_busy(busy), .o_done(done), .o_rdata(rdata),
        .o_address_latch_strobe(ale), .o_read_strobe_n(rd_n), .o_write_ctl(wctl),
        .o_byte_high_enable_n(bhe_n), .o_top_address_or_select(top), .o_third_port_pins(tp),
        .i_low_addr_data_lines(bus[7:0]), .o_low_addr_data_lines(host[7:0]),
        .o_low_addr_data_oe_n(oe_n[0]), .i_high_addr_data_lines(bus[15:8]),
        .o_high_addr_data_lines(host[15:8]), .o_high_addr_data_oe_n(oe_n[1]),
        .i_first_port_pins(bus[23:16]), .o_first_port_pins(host[23:16]),
        .o_first_port_oe_n(oe_n[2]), .i_second_port_pins(bus[31:24]),
        .o_second_port_pins(host[31:24]), .o_second_port_oe_n(oe_n[3]));

    mbp_dev_model i_dev (.i_ale(ale), .i_pol(pol), .i_rws(rws), .i_mode(mode),
        .i_rd_n(rd_n), .i_wr(wctl), .i_bhe_n(bhe_n), .i_host(host), .i_oe_n(oe_n),
        .o_bus(bus));

    task chk(input string n, input logic [19:0] s, input logic [19:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task test_done;
        if (fails == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One bus cycle; the request is raised at once, so rows run back to back
    task run(input mbp_row_type r);
        int n;
        mode = r.m;
        pol  = r.p;
        rws  = r.s;
        wr   = r.w;
        adr  = r.a;
        wd   = r.d;
        req  = 1;
        @(posedge clk);
        #2 req = 0;
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #2 n++;
            if (n == 2) begin
                chk("ale_on", ale, r.p);
            end
            if (n == 3) begin
                // Trailing edge has passed, the address must still stand
                chk("ale_off", ale, !r.p);
                chk("addr", bus[15:0], r.a[15:0]);
                chk("upper", {tp, top}, {r.a[18:16], r.a[19]});
                chk("bhe_n", bhe_n, !(r.m[0] && bh));
            end
            if (n == 8) begin
                chk("rd_n", rd_n, r.w && !r.s);
                chk("wctl", wctl, !r.w);
                chk("low_oe_n", oe_n[0], !r.m[1] && !r.w);
            end
        end
        if (n == 40) begin
            fails++;
            test_done;
        end
        chk("cycles", n, 13); // Take edge, then 2+1+8+1 phase cycles, then done seen
        if (!r.w) chk("rdata", rdata, r.d);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #2 rst_n = 1;
        chk("rdata_rst", rdata, 0);
        chk("oe_rst", oe_n, 4'hF);
        foreach (ROWS[i]) run(ROWS[i]);
        // A write with the high byte disabled must leave the stored high byte alone
        bh = 0;
        run(mbp_row_type'{mbp_pkg::MBP_NMUX16, 1'b1, 1'b1, 1'b1, 20'hF0F04, 16'h1111});
        bh = 1;
        run(mbp_row_type'{mbp_pkg::MBP_NMUX16, 1'b1, 1'b1, 1'b0, 20'hF0F04, 16'h5A11});
        // A new address while busy is refused; a reset mid-cycle idles all
        req = 1; adr = ROWS[0].a; mode = ROWS[0].m;
        @(posedge clk); #2 adr = 20'h7FFFF;
        repeat (3) @(posedge clk);
        #2 chk("refused", tp, ROWS[0].a[18:16]);
        rst_n = 0; req = 0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1;
        chk("busy_rst", busy, 0);
        chk("ale_rst", ale, 0);
        chk("oe_mid_rst", oe_n, 4'hF);
        test_done;
    end
endmodule

`default_nettype wire
